// >>> hw/sadc_pkg.sv
// Shared widths, timing counts and gain table for the converter link.
`default_nettype none
package sadc_pkg;
  // oscillator and widths
  localparam int SADC_CLK_NS = 20;
  localparam int SADC_DATA_W = 14;
  localparam int SADC_SEL_W = 3;
  localparam int SADC_WORD_W = SADC_DATA_W + 2 * SADC_SEL_W;
  localparam int SADC_PIN_W = 2 * SADC_SEL_W + 3;
  localparam int SADC_CNT_W = 5;
  localparam int SADC_TMR_W = 7;
  localparam int SADC_GAIN_FW = 5;
  localparam logic [SADC_CNT_W-1:0] SADC_LAST_IDX = 5'(SADC_WORD_W - 1);
  localparam logic [SADC_CNT_W-1:0] SADC_CNT_MAX = 5'h1F;
  localparam logic [SADC_CNT_W-1:0] SADC_BITS_SHORT = 5'(SADC_DATA_W);
  localparam logic [SADC_CNT_W-1:0] SADC_BITS_LONG = 5'(SADC_WORD_W);
  // conversion interval, longest time, rounded down
  localparam int SADC_CONV_BYP_NS = 660;
  localparam int SADC_CONV_PGA_NS = 1550;
  localparam logic [SADC_TMR_W-1:0] SADC_CONV_BYP_CYC = 7'(SADC_CONV_BYP_NS / SADC_CLK_NS);
  localparam logic [SADC_TMR_W-1:0] SADC_CONV_PGA_CYC = 7'(SADC_CONV_PGA_NS / SADC_CLK_NS);
  // chip-select high time, least time, rounded up
  localparam int SADC_CSH_NORM_NS = 150;
  localparam int SADC_CSH_LP_NS = 500;
  localparam logic [SADC_TMR_W-1:0] SADC_CSH_NORM_CYC =
    7'((SADC_CSH_NORM_NS + SADC_CLK_NS - 1) / SADC_CLK_NS);
  localparam logic [SADC_TMR_W-1:0] SADC_CSH_LP_CYC =
    7'((SADC_CSH_LP_NS + SADC_CLK_NS - 1) / SADC_CLK_NS);
  // serial clock: least period 20 ns; host half period in clk cycles
  localparam int SADC_SCK_MIN_NS = 20;
  localparam int SADC_SCK_HALF_NS = 40;
  localparam logic [SADC_TMR_W-1:0] SADC_SCK_HALF_CYC =
    7'((SADC_SCK_HALF_NS + SADC_CLK_NS - 1) / SADC_CLK_NS);

  function automatic logic [SADC_GAIN_FW-1:0] sadc_gain_factor(input logic [SADC_SEL_W-1:0] code);
    logic [SADC_GAIN_FW-1:0] g;
    g = 5'h00;
    unique case (code)
      3'h0: g = 5'h01;
      3'h1: g = 5'h02;
      3'h2: g = 5'h03;
      3'h3: g = 5'h04;
      3'h4: g = 5'h06;
      3'h5: g = 5'h08;
      3'h6: g = 5'h0C;
      3'h7: g = 5'h10;
    endcase
    return g;
  endfunction : sadc_gain_factor
endpackage : sadc_pkg
`default_nettype wire

// >>> hw/sadc_if.sv
// Pin-level link between the host controller and the converter.
`default_nettype none
interface sadc_if;
  import sadc_pkg::*;
  logic cs_n;
  logic sck;
  logic sdo;
  logic sdo_oe;
  logic busy;
  logic [SADC_SEL_W-1:0] channel_select_pins;
  logic [SADC_SEL_W-1:0] gain_select_pins;
  logic pga_bypass;
  logic low_power_select;
  logic power_down;

  modport dev (
    input cs_n, sck, channel_select_pins, gain_select_pins,
    input pga_bypass, low_power_select, power_down,
    output sdo, sdo_oe, busy
  );
  modport host (
    output cs_n, sck, channel_select_pins, gain_select_pins,
    output pga_bypass, low_power_select, power_down,
    input sdo, sdo_oe, busy
  );
endinterface : sadc_if
`default_nettype wire

// >>> hw/sadc_dev.sv
// Converter end: oscillator-timed conversion and serial readout on the link clock.
`default_nettype none
module sadc_dev
  import sadc_pkg::*;
(
  // internal oscillator and reset
  input wire logic clk,
  input wire logic srst,
  // link to the host
  sadc_if.dev link,
  // analogue front end
  input wire logic [SADC_DATA_W-1:0] analog_code,
  output logic [SADC_SEL_W-1:0] mux_channel_q,
  output logic [SADC_GAIN_FW-1:0] gain_factor_q,
  output logic pga_bypass_q,
  // conversion results
  output logic [SADC_DATA_W-1:0] result_q,
  output logic result_strobe_q,
  output logic result_invalid_q
);

  typedef enum logic [1:0] {
    DS_IDLE,
    DS_CONV,
    DS_READ
  } sadc_dstate_t;

  localparam int SYNC_W = SADC_PIN_W + SADC_DATA_W;

  sadc_dstate_t state_q;
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_prev_q;
  logic [SYNC_W-1:0] pin_s1_q;
  logic [SYNC_W-1:0] pin_s2_q;
  logic [SADC_SEL_W-1:0] s_chan;
  logic [SADC_SEL_W-1:0] s_gain;
  logic s_byp;
  logic s_lp;
  logic s_pd;
  logic [SADC_DATA_W-1:0] s_code;
  logic cs_fall;
  logic cs_rise;
  logic start;
  logic conv_done;
  logic [SADC_TMR_W-1:0] tmr_q;
  logic busy_q;
  logic oe_q;
  logic warm_q;
  logic [SADC_SEL_W-1:0] chan_q;
  logic [SADC_SEL_W-1:0] gain_q;
  logic [SADC_DATA_W-1:0] code_q;
  logic invalid_q;
  logic [SADC_WORD_W-1:0] word_d;
  logic [SADC_WORD_W-1:0] word_q;
  logic sdo_a_q;
  logic sdo_b_q;
  logic [SADC_CNT_W-1:0] edge_q;
  logic [SADC_CNT_W-1:0] edge_nxt;

  // pins from the host cross in through two flops
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_prev_q <= 1'b1;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      cs_s1_q <= link.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_prev_q <= cs_s2_q;
      pin_s1_q <= {link.channel_select_pins, link.gain_select_pins, link.pga_bypass,
                   link.low_power_select, link.power_down, analog_code};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign {s_chan, s_gain, s_byp, s_lp, s_pd, s_code} = pin_s2_q;
  assign cs_fall = cs_prev_q & ~cs_s2_q;
  assign cs_rise = ~cs_prev_q & cs_s2_q;
  assign start = cs_fall & ~s_pd & (state_q != DS_CONV);
  assign conv_done = (state_q == DS_CONV) && (tmr_q == 7'h01);
  assign word_d = {code_q, chan_q, gain_q};

  // oscillator-timed conversion
  // cs fall to busy rise is three clk cycles, inside the enabled-amplifier limit only
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= DS_IDLE;
      tmr_q <= '0;
      busy_q <= 1'b0;
    end else begin
      unique case (state_q)
        DS_IDLE, DS_READ: begin
          if (start) begin
            state_q <= DS_CONV;
            busy_q <= 1'b1;
            tmr_q <= s_byp ? SADC_CONV_BYP_CYC : SADC_CONV_PGA_CYC;
          end else if (cs_rise) begin
            state_q <= DS_IDLE;
          end
        end
        DS_CONV: begin
          if (conv_done) begin
            state_q <= DS_READ;
            busy_q <= 1'b0;
          end else begin
            tmr_q <= tmr_q - 7'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      chan_q <= '0;
      gain_q <= '0;
      code_q <= '0;
      invalid_q <= 1'b0;
      mux_channel_q <= '0;
      gain_factor_q <= 5'h01;
      pga_bypass_q <= 1'b0;
    end else if (start) begin
      chan_q <= s_chan;
      gain_q <= s_gain;
      code_q <= s_code;
      invalid_q <= ~warm_q & ~s_lp;
      mux_channel_q <= s_chan;
      gain_factor_q <= sadc_gain_factor(s_gain);
      pga_bypass_q <= s_byp;
    end
  end

  // circuitry wakes on the first select pulse after power-up or power-down
  always_ff @(posedge clk) begin
    if (srst || s_pd) begin
      warm_q <= 1'b0;
    end else if (cs_rise) begin
      warm_q <= 1'b1;
    end
  end

  // result word held until the next conversion ends
  always_ff @(posedge clk) begin
    if (srst) begin
      word_q <= '0;
    end else if (conv_done) begin
      word_q <= word_d;
    end
  end

  // sdo is a_q ^ b_q; b_q is zero whenever select is high, so a_q alone sets the first bit
  always_ff @(posedge clk) begin
    if (srst) begin
      sdo_a_q <= 1'b0;
    end else if (start) begin
      sdo_a_q <= 1'b0;
    end else if (conv_done) begin
      sdo_a_q <= word_d[SADC_WORD_W-1];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~cs_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      result_q <= '0;
      result_strobe_q <= 1'b0;
      result_invalid_q <= 1'b0;
    end else begin
      result_strobe_q <= conv_done;
      if (conv_done) begin
        result_q <= code_q;
        result_invalid_q <= invalid_q;
      end
    end
  end

  assign edge_nxt = (edge_q == SADC_CNT_MAX) ? edge_q : edge_q + 5'h01;

  // link-clock domain, cleared by the frame's own select; word_q and sdo_a_q
  // are only read here while quiet, since the host gives no edges during busy
  // no edges while converting
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      edge_q <= '0;
      sdo_b_q <= 1'b0;
    end else begin
      edge_q <= edge_nxt;
      if (edge_nxt <= SADC_LAST_IDX) begin
        sdo_b_q <= sdo_a_q ^ word_q[SADC_LAST_IDX - edge_nxt];
      end else begin
        sdo_b_q <= sdo_a_q;
      end
    end
  end

  assign link.busy = busy_q;
  assign link.sdo_oe = oe_q;
  assign link.sdo = sdo_a_q ^ sdo_b_q;

endmodule : sadc_dev
`default_nettype wire

// >>> hw/sadc_host.sv
// Host end: drives select, serial clock and pins, collects words into a two-entry buffer.
`default_nettype none
module sadc_host
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // user control
  input wire logic run,
  input wire logic [SADC_SEL_W-1:0] channel_sel,
  input wire logic [SADC_SEL_W-1:0] gain_sel,
  input wire logic pga_bypass,
  input wire logic low_power,
  input wire logic power_down,
  input wire logic read_tail,
  // result stream
  output logic res_valid_q,
  output logic [SADC_WORD_W-1:0] res_data_q,
  input wire logic res_ready,
  // link to the converter
  sadc_if.host link
);

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_WBUSY,
    HS_CONV,
    HS_LOW,
    HS_HIGH
  } sadc_hstate_t;

  sadc_hstate_t state_q;
  logic [SADC_TMR_W-1:0] tmr_q;
  logic [SADC_CNT_W-1:0] bits_q;
  logic tail_q;
  logic [SADC_WORD_W-1:0] shreg_q;
  logic cs_n_q;
  logic sck_q;
  logic [SADC_PIN_W-1:0] pins_q;
  logic [SADC_PIN_W-1:0] pins_d;
  logic [1:0] in_s1_q;
  logic [1:0] in_s2_q;
  logic busy_s;
  logic sdo_s;
  logic [SADC_TMR_W-1:0] csh_cyc;
  logic last_bit;
  logic push;
  logic [SADC_WORD_W-1:0] rx_word;
  logic [SADC_WORD_W-1:0] push_data;
  logic pop;
  logic [SADC_WORD_W-1:0] spare_q;
  logic spare_v_q;

  assign pins_d = {channel_sel, gain_sel, pga_bypass, low_power, power_down};
  assign csh_cyc = low_power ? SADC_CSH_LP_CYC : SADC_CSH_NORM_CYC;
  assign {busy_s, sdo_s} = in_s2_q;
  assign last_bit = (bits_q + 5'h01) == (tail_q ? SADC_BITS_LONG : SADC_BITS_SHORT);
  assign push = (state_q == HS_LOW) && (tmr_q == '0) && last_bit;
  assign rx_word = {shreg_q[SADC_WORD_W-2:0], sdo_s};
  assign push_data = tail_q ? rx_word :
    {rx_word[SADC_DATA_W-1:0], pins_q[SADC_PIN_W-1 -: 2 * SADC_SEL_W]};
  assign pop = res_valid_q & res_ready;

  always_ff @(posedge clk) begin
    if (srst) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
    end else begin
      in_s1_q <= {link.busy, link.sdo};
      in_s2_q <= in_s1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= HS_IDLE;
      tmr_q <= SADC_CSH_LP_CYC - 7'h01;
      bits_q <= '0;
      tail_q <= 1'b0;
      shreg_q <= '0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      pins_q <= '0;
    end else begin
      unique case (state_q)
        HS_IDLE: begin
          // pins settle a full high time before select falls
          if (pins_d != pins_q) begin
            pins_q <= pins_d;
            tmr_q <= csh_cyc - 7'h01;
          end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - 7'h01;
          end else if (run && !power_down && !spare_v_q) begin
            state_q <= HS_WBUSY;
            cs_n_q <= 1'b0;
            tail_q <= read_tail;
            bits_q <= '0;
          end
        end
        HS_WBUSY: begin
          if (busy_s) begin
            state_q <= HS_CONV;
          end
        end
        HS_CONV: begin
          // clock held low until busy falls
          if (!busy_s) begin
            state_q <= HS_LOW;
            tmr_q <= SADC_SCK_HALF_CYC - 7'h01;
          end
        end
        HS_LOW: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - 7'h01;
          end else begin
            shreg_q <= rx_word;
            bits_q <= bits_q + 5'h01;
            if (last_bit) begin
              state_q <= HS_IDLE;
              cs_n_q <= 1'b1;
              tmr_q <= csh_cyc - 7'h01;
            end else begin
              // half period of two clk cycles keeps sck at 12.5 MHz
              state_q <= HS_HIGH;
              sck_q <= 1'b1;
              tmr_q <= SADC_SCK_HALF_CYC - 7'h01;
            end
          end
        end
        HS_HIGH: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - 7'h01;
          end else begin
            state_q <= HS_LOW;
            sck_q <= 1'b0;
            tmr_q <= SADC_SCK_HALF_CYC - 7'h01;
          end
        end
        default: begin
          state_q <= HS_IDLE;
          cs_n_q <= 1'b1;
          sck_q <= 1'b0;
        end
      endcase
    end
  end

  // two-entry buffer; a frame starts only with the spare slot free, so a push always fits
  always_ff @(posedge clk) begin
    if (srst) begin
      res_valid_q <= 1'b0;
      res_data_q <= '0;
      spare_q <= '0;
      spare_v_q <= 1'b0;
    end else if (pop && spare_v_q) begin
      res_data_q <= spare_q;
      spare_v_q <= push;
      if (push) begin
        spare_q <= push_data;
      end
    end else if (pop || !res_valid_q) begin
      res_valid_q <= push;
      if (push) begin
        res_data_q <= push_data;
      end
    end else if (push) begin
      spare_q <= push_data;
      spare_v_q <= 1'b1;
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign {link.channel_select_pins, link.gain_select_pins, link.pga_bypass,
          link.low_power_select, link.power_down} = pins_q;

endmodule : sadc_host
`default_nettype wire

// >>> test/sadc_props.sv
// Checker for the select, serial clock, data and busy wires of the converter link.
`default_nettype none
module sadc_props
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link wires
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic busy,
  input wire logic pga_bypass,
  input wire logic low_power_select,
  input wire logic power_down
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic busy_p_q;
  logic sck_p_q;
  logic rd_q;
  logic [SADC_TMR_W-1:0] bcnt_q;
  logic [SADC_TMR_W-1:0] hcnt_q;
  logic [SADC_CNT_W-1:0] rcnt_q;

  always_ff @(posedge clk) begin
    busy_p_q <= srst ? 1'b0 : busy;
    sck_p_q <= srst ? 1'b0 : sck;
  end
  // readout phase: from busy fall until select goes high
  always_ff @(posedge clk) begin
    rd_q <= (srst || cs_n) ? 1'b0 : ((busy_p_q && !busy) ? 1'b1 : rd_q);
  end
  always_ff @(posedge clk) begin
    bcnt_q <= (srst || !busy) ? 7'h00 : bcnt_q + 7'h01;
  end
  // saturates so a long idle cannot wrap back below the limit
  always_ff @(posedge clk) begin
    if (srst || !cs_n) begin
      hcnt_q <= 7'h00;
    end else if (hcnt_q != 7'h7F) begin
      hcnt_q <= hcnt_q + 7'h01;
    end
  end
  always_ff @(posedge clk) begin
    rcnt_q <= (srst || cs_n) ? 5'h00 : rcnt_q + 5'(sck && !sck_p_q);
  end

  busy_start_a: assert property (
    $fell(cs_n) && !power_down |-> ##[2:4] $rose(busy))
    else $error("busy did not follow select fall");
  conv_len_a: assert property (
    $fell(busy) |-> bcnt_q == (pga_bypass ? SADC_CONV_BYP_CYC : SADC_CONV_PGA_CYC))
    else $error("conversion length wrong");
  csh_time_a: assert property (
    $fell(cs_n) |-> hcnt_q >= (low_power_select ? SADC_CSH_LP_CYC : SADC_CSH_NORM_CYC))
    else $error("select high time too short");
  sck_quiet_a: assert property (
    busy |-> !sck)
    else $error("serial clock high during conversion");
  msb_ready_a: assert property (
    $fell(busy) |-> sdo_oe && !sck)
    else $error("data not presented at busy fall");
  shift_edge_a: assert property (
    rd_q && !cs_n && $changed(sdo) |-> $rose(sck))
    else $error("data changed without a clock rise");
  oe_idle_a: assert property (
    cs_n [*5] |-> !sdo_oe)
    else $error("data driven while deselected");
  oe_drive_a: assert property (
    $fell(cs_n) && !power_down |-> ##[2:4] (sdo_oe && !sdo))
    else $error("data not driven low after select fall");
  oe_hold_a: assert property (
    !cs_n && (busy || rd_q) |-> sdo_oe)
    else $error("data released inside a frame");
  edge_count_a: assert property (
    $rose(cs_n) |-> rcnt_q == 5'h0D || rcnt_q == 5'h13)
    else $error("clock rise count per frame wrong");

  cover property ($fell(busy) && pga_bypass);
  cover property ($fell(busy) && !pga_bypass);
  cover property ($rose(cs_n) && rcnt_q == 5'h13);
endmodule : sadc_props
`default_nettype wire

// >>> test/test_sar_adc_serial_readout.sv
// Self-checking bench: both link ends joined, frames run from the user sides.
`default_nettype none
module test_sar_adc_serial_readout
  import sadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic run = 1'b0;
  logic [SADC_SEL_W-1:0] chan = 3'h0;
  logic [SADC_SEL_W-1:0] gain = 3'h0;
  logic byp = 1'b0;
  logic lp = 1'b0;
  logic pd = 1'b0;
  logic tail = 1'b0;
  logic res_ready = 1'b0;
  logic [SADC_DATA_W-1:0] code = 14'h0000;
  logic res_valid;
  logic [SADC_WORD_W-1:0] res_data;
  logic [SADC_SEL_W-1:0] mux_q;
  logic [SADC_GAIN_FW-1:0] gf_q;
  logic byp_q;
  logic [SADC_DATA_W-1:0] result;
  logic strobe;
  logic invalid;
  logic [SADC_DATA_W-1:0] res_cap;
  logic inv_cap;
  logic [SADC_WORD_W-1:0] wire_bits;
  logic busy_p, sck_p, cs_p;
  int wire_n;
  int falls;
  int fail_count = 0;
  int checks = 0;
  localparam logic [SADC_GAIN_FW-1:0] GTAB [8] = '{5'h01, 5'h02, 5'h03, 5'h04,
    5'h06, 5'h08, 5'h0C, 5'h10};

  sadc_if sadc_if_inst ();
  sadc_dev sadc_dev_inst (
    .clk(clk), .srst(srst), .link(sadc_if_inst.dev), .analog_code(code),
    .mux_channel_q(mux_q), .gain_factor_q(gf_q), .pga_bypass_q(byp_q),
    .result_q(result), .result_strobe_q(strobe), .result_invalid_q(invalid)
  );
  sadc_host sadc_host_inst (
    .clk(clk), .srst(srst), .run(run), .channel_sel(chan), .gain_sel(gain),
    .pga_bypass(byp), .low_power(lp), .power_down(pd), .read_tail(tail),
    .res_valid_q(res_valid), .res_data_q(res_data), .res_ready(res_ready),
    .link(sadc_if_inst.host)
  );
  sadc_props sadc_props_inst (
    .clk(clk), .srst(srst), .cs_n(sadc_if_inst.cs_n), .sck(sadc_if_inst.sck),
    .sdo(sadc_if_inst.sdo), .sdo_oe(sadc_if_inst.sdo_oe), .busy(sadc_if_inst.busy),
    .pga_bypass(sadc_if_inst.pga_bypass), .low_power_select(sadc_if_inst.low_power_select),
    .power_down(sadc_if_inst.power_down)
  );

  always #10 clk = ~clk;

  // wire bits are read at busy fall and after each serial clock fall
  always @(posedge clk) begin
    busy_p <= sadc_if_inst.busy;
    sck_p <= sadc_if_inst.sck;
    cs_p <= sadc_if_inst.cs_n;
    if ((busy_p && !sadc_if_inst.busy) || (sck_p && !sadc_if_inst.sck && !sadc_if_inst.cs_n)) begin
      wire_bits <= {wire_bits[SADC_WORD_W-2:0], sadc_if_inst.sdo};
      wire_n <= wire_n + 1;
    end
    if (cs_p && !sadc_if_inst.cs_n) begin
      falls <= falls + 1;
    end
    if (strobe) begin
      res_cap <= result;
      inv_cap <= invalid;
    end
  end

  task automatic complete_run();
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [SADC_WORD_W-1:0] got, input logic [SADC_WORD_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // bounded, so a stuck link shows up as a mismatch rather than a hang
  task automatic wait_on(input bit for_cs);
    int n;
    n = 0;
    while ((for_cs ? sadc_if_inst.cs_n !== 1'b0 : res_valid !== 1'b1) && n < 3000) begin
      tick(1);
      n++;
    end
    chk(20'(n < 3000), 20'h00001);
  endtask : wait_on

  task automatic pop_word(input logic [SADC_WORD_W-1:0] exp);
    wait_on(1'b0);
    chk(res_data, exp);
    res_ready = 1'b1;
    tick(1);
    res_ready = 1'b0;
    // let an edge pass so a second pop never re-raises ready in the same step
    tick(1);
  endtask : pop_word

  task automatic frame(input int i);
    logic [SADC_WORD_W-1:0] exp;
    int n0;
    chan = 3'(i);
    gain = ~3'(i);
    byp = i[0];
    tail = !i[1];
    lp = (i == 2 || i == 5 || i == 9);
    code = (i == 1) ? 14'h3FFF : ((i == 2) ? 14'h0000 : 14'h2A5C + 14'(i) * 14'h0265);
    pd = (i >= 8);
    tick(4);
    pd = 1'b0;
    n0 = wire_n;
    run = 1'b1;
    wait_on(1'b1);
    run = 1'b0;
    exp = {code, chan, gain};
    pop_word(exp);
    chk(20'(wire_n - n0), tail ? 20'h00014 : 20'h0000E);
    chk(tail ? wire_bits : 20'(wire_bits[SADC_DATA_W-1:0]), tail ? exp : 20'(code));
    chk(20'(res_cap), 20'(code));
    chk(20'(inv_cap), 20'(i == 0 || i == 8));
    chk(20'({mux_q, gf_q, byp_q}), 20'({chan, GTAB[gain], byp}));
  endtask : frame

  initial begin
    int f0;
    tick(10);
    srst = 1'b0;
    chk(20'({sadc_if_inst.cs_n, sadc_if_inst.sck, sadc_if_inst.sdo_oe}), 20'h00004);
    chk(20'({res_valid, sadc_if_inst.busy, gf_q}), 20'h00001);
    chk(20'(result), 20'h00000);
    for (int i = 0; i < 10; i++) begin
      frame(i);
    end
    // the reader stalls: two words fill the buffer and no third frame starts
    chan = 3'h5;
    gain = 3'h2;
    byp = 1'b1;
    tail = 1'b1;
    lp = 1'b0;
    code = 14'h1234;
    f0 = falls;
    run = 1'b1;
    tick(1500);
    chk(20'(falls - f0), 20'h00002);
    run = 1'b0;
    pop_word({14'h1234, 3'h5, 3'h2});
    pop_word({14'h1234, 3'h5, 3'h2});
    tick(2);
    chk(20'(res_valid), 20'h00000);
    // a second reset makes the next normal-mode sample invalid again
    srst = 1'b1;
    tick(3);
    srst = 1'b0;
    frame(0);
    complete_run();
  end

  // thirteen frames of a few hundred cycles plus the stall fit well inside this
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule : test_sar_adc_serial_readout
`default_nettype wire
